// *** core/mem_block_params.svh ***
// Constants for the embedded memory block: register offsets, field positions, reset values, sizes.
// Assumes a 32-bit APB slave whose registers each take one aligned word.
`ifndef MEM_BLOCK_PARAMS_SVH
`define MEM_BLOCK_PARAMS_SVH

`define MB_AW 8
`define MB_OFF_CTRL 8'h00
`define MB_OFF_ADDR 8'h04
`define MB_OFF_WDATA 8'h08
`define MB_OFF_CARE 8'h0c
`define MB_OFF_CMD 8'h10
`define MB_OFF_RDATA 8'h14
`define MB_OFF_KEY 8'h18
`define MB_OFF_STATUS 8'h1c
`define MB_OFF_LINES 8'h20

`define MB_CTRL_W 16
`define MB_CTRL_RST 16'hc080
`define MB_CARE_RST 32'hffff_ffff
`define MB_CMP_31 32'h7fff_ffff
`define MB_ADDR_W 9
`define MB_HALF_BIT 8
`define MB_RAM_DEPTH 256
`define MB_RAM_W 16
`define MB_HALF_W 8
`define MB_CAM_DEPTH 32
`define MB_CAM_W 32
`define MB_LINES 16
`define MB_FAST_MASK 32'h0000_ffff
`define MB_ROM_SEED 16'h5a00

`define MB_CMD_RAM_WR 0
`define MB_CMD_RAM_RD 1
`define MB_CMD_CAM_WR 2
`define MB_CMD_CAM_LK 3

`define MB_ST_BUSY 0
`define MB_ST_MATCH 1
`define MB_ST_ENC_LO 2
`define MB_ST_PDOWN 7

`endif

// *** core/mem_block_pkg.sv ***
// Types for the embedded memory block: control word layout, modes and sequencer states.
// Field positions match the layout of the control register in the params header.
package mem_block_pkg;

    typedef enum logic [1:0] {
        MODE_RAM = 2'h0,
        MODE_CAM = 2'h1,
        MODE_ROM = 2'h2
    } mode_t;

    typedef enum logic [1:0] {
        CAM_SINGLE = 2'h0,
        CAM_MULTI = 2'h1,
        CAM_FAST = 2'h2
    } cam_mode_t;

    typedef struct packed {
        logic out_gate;
        logic in_gate;
        logic re_reg;
        logic we_reg;
        logic waddr_reg;
        logic raddr_reg;
        logic dout_reg;
        logic din_reg;
        logic enable;
        logic low_power;
        logic split;
        logic encoded;
        cam_mode_t cam_mode;
        mode_t mode;
    } ctrl_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PREP = 6'h02,
        ST_EXEC = 6'h04,
        ST_EXTRA = 6'h08,
        ST_CARE = 6'h10,
        ST_OUT = 6'h20
    } state_t;

endpackage

// *** core/mem_block.sv ***
// Embedded memory block: single-port RAM, ROM lookup table and 32x32 CAM behind an APB slave.
// Assumes an APB master on pclk; all storage is flip-flops preset by presetn.
//
// Function
// - Single-port RAM, splittable into two halves
// - Every register loads its reset value asynchronously on reset
// - Parallel compare, return location, raise match
// - CAM holds 32 words of 32 bits
// - Don't-care stored bits never block match
// - Three output modes, encoded or unencoded
// - Encoded output gives binary match address
// - Sixteen one-hot lines, all words over two
// - Single-match unencoded compare uses only 31 bits
// - Select one gives odd words, zero even
// - Single-match: write two cycles, lookup one
// - Single-match gives both outputs without help
// - Multiple-match: 16 lines per cycle, two
// - Fast multiple-match: one cycle, 16 words
// - CAM preloaded at reset or written live
// - CAM write two cycles, third for mask
// - Per-path input and output registering options
// - Input and output stages gated separately
// - Read-only lookup table with fixed contents
// - Low-power setting adds delay; unused powers down
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "mem_block_params.svh"

module mem_block (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic match_flag,
    output logic power_down
);
    import mem_block_pkg::*;

    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic match_reg;
    logic power_down_reg;
    ctrl_t ctrl_reg;
    logic [`MB_ADDR_W-1:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] care_reg;
    logic [31:0] key_reg;
    logic [3:0] op_reg;
    state_t state_reg;
    state_t state_next;
    logic [`MB_RAM_W-1:0] mem_reg [`MB_RAM_DEPTH];
    logic [`MB_CAM_W-1:0] cam_val_reg [`MB_CAM_DEPTH];
    logic [`MB_CAM_W-1:0] cam_care_reg [`MB_CAM_DEPTH];
    logic [`MB_RAM_W-1:0] rd_stage_reg;
    logic [31:0] lines_stage_reg;
    logic [4:0] enc_stage_reg;
    logic match_stage_reg;
    logic [`MB_RAM_W-1:0] rdata_reg;
    logic [31:0] lines_reg;
    logic [4:0] enc_reg;

    logic access;
    logic xfer;
    logic [`MB_AW-1:0] off;
    logic mapped;
    logic cmd_hit;
    logic cmd_ok;
    logic need_prep;
    logic publish;
    logic [31:0] cmp_mask;
    logic [`MB_CAM_DEPTH-1:0] hit;
    logic [`MB_CAM_DEPTH-1:0] hit_used;
    logic [`MB_LINES-1:0] even_lines;
    logic [`MB_LINES-1:0] odd_lines;
    logic [`MB_RAM_W-1:0] rd_word;
    logic [4:0] cam_idx;
    logic [7:0] ram_idx;
    logic ram_we;
    logic cam_val_we;
    logic cam_care_we;
    logic single_unenc;

    function automatic logic [4:0] lowest(input logic [`MB_CAM_DEPTH-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = `MB_CAM_DEPTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign match_flag = match_reg;
    assign power_down = power_down_reg;

    // APB: answer one cycle into the access phase, act on the edge that samples pready
    assign access = psel && penable && !pready_reg;
    // A refused transfer changes nothing: the error flag stands beside pready
    assign xfer = psel && penable && pready_reg && !pslverr_reg;
    assign off = paddr[`MB_AW-1:0];
    assign mapped = (paddr[31:`MB_AW] == '0) && (off[1:0] == 2'h0) && (off <= `MB_OFF_LINES);
    assign cmd_hit = pwrite && (off == `MB_OFF_CMD);
    // A command while busy, powered down or with the input stage gated off is refused
    assign cmd_ok = (state_reg == ST_IDLE) && ctrl_reg.enable && ctrl_reg.in_gate;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access && (!mapped || (cmd_hit && !cmd_ok));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (access && !mapped) begin
            prdata_reg <= 32'h0000_0000;
        end else if (access) begin
            case (off)
                `MB_OFF_CTRL: prdata_reg <= {16'h0000, ctrl_reg};
                `MB_OFF_ADDR: prdata_reg <= {23'h000000, addr_reg};
                `MB_OFF_WDATA: prdata_reg <= wdata_reg;
                `MB_OFF_CARE: prdata_reg <= care_reg;
                `MB_OFF_RDATA: prdata_reg <= {16'h0000, rdata_reg};
                `MB_OFF_KEY: prdata_reg <= key_reg;
                `MB_OFF_STATUS: prdata_reg <= {24'h000000, power_down_reg, enc_reg, match_reg,
                                               state_reg != ST_IDLE};
                `MB_OFF_LINES: prdata_reg <= lines_reg;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Software-visible configuration and operands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ctrl_t'(`MB_CTRL_RST);
            addr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            care_reg <= `MB_CARE_RST;
            key_reg <= 32'h0000_0000;
        end else if (xfer && pwrite) begin
            case (off)
                `MB_OFF_CTRL: ctrl_reg <= ctrl_t'(pwdata[`MB_CTRL_W-1:0]);
                `MB_OFF_ADDR: addr_reg <= pwdata[`MB_ADDR_W-1:0];
                `MB_OFF_WDATA: wdata_reg <= pwdata;
                `MB_OFF_CARE: care_reg <= pwdata;
                `MB_OFF_KEY: key_reg <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_reg <= 1'b1;
        end else begin
            power_down_reg <= !ctrl_reg.enable;
        end
    end

    // Extra input stage in low-power setting, or when a used path is registered (CAM commands check only din_reg);
    // taken from the command word itself, as op_reg loads on the same edge
    always_comb begin
        need_prep = ctrl_reg.low_power;
        if (pwdata[`MB_CMD_RAM_WR]) begin
            need_prep = need_prep | ctrl_reg.din_reg | ctrl_reg.waddr_reg | ctrl_reg.we_reg;
        end
        if (pwdata[`MB_CMD_RAM_RD]) begin
            need_prep = need_prep | ctrl_reg.raddr_reg | ctrl_reg.re_reg;
        end
        if (pwdata[`MB_CMD_CAM_WR] || pwdata[`MB_CMD_CAM_LK]) begin
            need_prep = need_prep | ctrl_reg.din_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= 4'h0;
        end else if (xfer && cmd_hit && cmd_ok) begin
            op_reg <= pwdata[3:0];
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (xfer && cmd_hit && cmd_ok && (pwdata[3:0] != 4'h0)) begin
                    state_next = ST_PREP;
                end
            end
            ST_PREP: begin
                state_next = ST_EXEC;
            end
            ST_EXEC: begin
                if (op_reg[`MB_CMD_CAM_WR]) begin
                    state_next = ST_EXTRA;
                end else if (op_reg[`MB_CMD_CAM_LK] && ctrl_reg.cam_mode == CAM_MULTI) begin
                    state_next = ST_EXTRA;
                end else if ((op_reg[`MB_CMD_RAM_RD] || op_reg[`MB_CMD_CAM_LK]) && ctrl_reg.dout_reg) begin
                    state_next = ST_OUT;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_EXTRA: begin
                if (op_reg[`MB_CMD_CAM_WR]) begin
                    state_next = (care_reg != `MB_CARE_RST) ? ST_CARE : ST_IDLE;
                end else begin
                    state_next = ctrl_reg.dout_reg ? ST_OUT : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else if (state_reg == ST_IDLE && state_next == ST_PREP && !need_prep) begin
            state_reg <= ST_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // RAM / ROM array, preset with the lookup pattern; write pulse made internally
    assign ram_idx = addr_reg[7:0];
    assign ram_we = (state_reg == ST_EXEC) && op_reg[`MB_CMD_RAM_WR] && ctrl_reg.mode == MODE_RAM;
    assign rd_word = mem_reg[ram_idx];

    generate
        for (genvar g = 0; g < `MB_RAM_DEPTH; g++) begin : g_ram
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_reg[g] <= `MB_ROM_SEED ^ 16'(g);
                end else if (ram_we && ram_idx == 8'(g)) begin
                    if (!ctrl_reg.split) begin
                        mem_reg[g] <= wdata_reg[`MB_RAM_W-1:0];
                    end else if (addr_reg[`MB_HALF_BIT]) begin
                        mem_reg[g][`MB_RAM_W-1:`MB_HALF_W] <= wdata_reg[`MB_HALF_W-1:0];
                    end else begin
                        mem_reg[g][`MB_HALF_W-1:0] <= wdata_reg[`MB_HALF_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // CAM storage: value then mask; preloaded with word i holding i and full compare
    assign cam_idx = addr_reg[4:0];
    assign cam_val_we = (state_reg == ST_EXTRA) && op_reg[`MB_CMD_CAM_WR] && ctrl_reg.mode == MODE_CAM;
    assign cam_care_we = (state_reg == ST_CARE) && ctrl_reg.mode == MODE_CAM;

    assign single_unenc = ctrl_reg.cam_mode == CAM_SINGLE && !ctrl_reg.encoded;
    assign cmp_mask = single_unenc ? `MB_CMP_31 : `MB_CARE_RST;

    generate
        for (genvar g = 0; g < `MB_CAM_DEPTH; g++) begin : g_cam
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cam_val_reg[g] <= 32'(g);
                    cam_care_reg[g] <= `MB_CARE_RST;
                end else if (cam_val_we && cam_idx == 5'(g)) begin
                    cam_val_reg[g] <= wdata_reg;
                    cam_care_reg[g] <= `MB_CARE_RST;
                end else if (cam_care_we && cam_idx == 5'(g)) begin
                    cam_care_reg[g] <= care_reg;
                end
            end
            assign hit[g] = ((cam_val_reg[g] ^ key_reg) & cam_care_reg[g] & cmp_mask) == '0;
        end
        for (genvar k = 0; k < `MB_LINES; k++) begin : g_lines
            assign even_lines[k] = hit[2 * k];
            assign odd_lines[k] = hit[2 * k + 1];
        end
    endgenerate

    assign hit_used = (ctrl_reg.cam_mode == CAM_FAST) ? (hit & `MB_FAST_MASK) : hit;

    // Result staging; published only when the output stage is gated on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_stage_reg <= '0;
            lines_stage_reg <= 32'h0000_0000;
            enc_stage_reg <= 5'h00;
            match_stage_reg <= 1'b0;
        end else if (state_reg == ST_EXEC) begin
            if (op_reg[`MB_CMD_RAM_RD]) begin
                rd_stage_reg <= rd_word;
            end
            if (op_reg[`MB_CMD_CAM_LK]) begin
                match_stage_reg <= |hit_used;
                enc_stage_reg <= lowest(hit_used);
                case (ctrl_reg.cam_mode)
                    CAM_SINGLE: lines_stage_reg <= {16'h0000, key_reg[31] ? odd_lines : even_lines};
                    CAM_MULTI: lines_stage_reg <= {16'h0000, even_lines};
                    CAM_FAST: lines_stage_reg <= {16'h0000, hit_used[`MB_LINES-1:0]};
                    default: lines_stage_reg <= 32'h0000_0000;
                endcase
            end
        end else if (state_reg == ST_EXTRA && op_reg[`MB_CMD_CAM_LK]) begin
            lines_stage_reg[31:16] <= odd_lines;
        end
    end

    assign publish = ctrl_reg.out_gate && (state_reg != state_next || state_reg == ST_OUT) &&
                     (state_next == ST_IDLE) && (op_reg[`MB_CMD_RAM_RD] || op_reg[`MB_CMD_CAM_LK]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
            lines_reg <= 32'h0000_0000;
            enc_reg <= 5'h00;
            match_reg <= 1'b0;
        end else if (publish && state_reg == ST_OUT) begin
            rdata_reg <= rd_stage_reg;
            lines_reg <= lines_stage_reg;
            enc_reg <= enc_stage_reg;
            match_reg <= match_stage_reg;
        end else if (publish && op_reg[`MB_CMD_RAM_RD] && state_reg == ST_EXEC) begin
            rdata_reg <= rd_word;
        end else if (publish && state_reg == ST_EXEC) begin
            lines_reg <= (ctrl_reg.cam_mode == CAM_FAST) ? {16'h0000, hit_used[`MB_LINES-1:0]}
                         : {16'h0000, key_reg[31] ? odd_lines : even_lines};
            enc_reg <= lowest(hit_used);
            match_reg <= |hit_used;
        end else if (publish && state_reg == ST_EXTRA) begin
            lines_reg <= {odd_lines, lines_stage_reg[15:0]};
            enc_reg <= enc_stage_reg;
            match_reg <= match_stage_reg;
        end
    end

endmodule

// *** dv/mem_block_props.sv ***
// Concurrent checks on the memory block's APB port, match flag and power-down pin.
// Sees only the top module's ports; bound into the design from the bench top file.
`timescale 1ns/1ns

module mem_block_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic match_flag,
    input wire logic power_down
);
    import mem_block_pkg::*;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [3:0] since_cmd;
    wire done = psel && penable && pready;

    // Cycles since the last completed command write, refused or not, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_cmd <= 4'hf;
        end else if (done && pwrite && paddr == 32'h0000_0010) begin
            since_cmd <= 4'h0;
        end else if (since_cmd != 4'hf) begin
            since_cmd <= since_cmd + 4'h1;
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence

    sequence one_wait_s;
        (psel && penable && !pready) ##1 (psel && penable && pready);
    endsequence

    chk_one_wait: assert property (setup_s |=> one_wait_s)
        else $error("access phase did not end after exactly one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stayed high for more than one cycle");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    chk_err_unmapped: assert property (psel && penable && !pready && (paddr > 32'h0000_0020 || paddr[1:0] != 2'h0)
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused with zero data");
    chk_pd_follows: assert property (done && pwrite && paddr == 32'h0 |-> ##2 (power_down == !$past(pwdata[7], 2)))
        else $error("power_down does not follow the enable bit");
    chk_pd_refuse: assert property (done && pwrite && paddr == 32'h0000_0010 && power_down |-> pslverr)
        else $error("command accepted while powered down");
    chk_status_mirror: assert property (done && !pwrite && paddr == 32'h0000_001c && !prdata[0]
        |-> prdata[1] == match_flag && prdata[7] == power_down)
        else $error("status bits disagree with match_flag or power_down");
    chk_match_cause: assert property ($changed(match_flag) |-> since_cmd <= 4'h6)
        else $error("match_flag changed without a recent command");
endmodule

// *** dv/mem_block_apb_master.sv ***
// Fabric-side model: an APB master that issues one transfer per call.
// Assumes the slave answers with pready; a wait beyond the bound raises hung.
`timescale 1ns/1ns

module mem_block_apb_master (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    output logic hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request held unchanged until pready is sampled high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            hung <= 1'b1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines carry no stale request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// *** dv/mem_block_bench.sv ***
// Self-checking bench for the memory block: RAM, split, ROM, CAM modes and refusals over APB.
// Assumes the APB master model and the checker sit beside the design.
`timescale 1ns/1ns

module mem_block_bench;
    import mem_block_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, match_flag, power_down, hung, ev;
    logic stuck = 1'b0;
    logic [31:0] paddr, pwdata, prdata, rv;
    int mismatches = 0;
    int check_count = 0;

    always #5 pclk = ~pclk;

    mem_block dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match_flag(match_flag), .power_down(power_down));

    mem_block_apb_master pm_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        pm_u.xfer(1'b1, a, d, rv, ev);
    endtask

    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp,
                       input logic [31:0] mask = 32'hffff_ffff);
        pm_u.xfer(1'b0, a, 32'h0, rv, ev);
        check(what, rv & mask, exp);
    endtask

    // Polls the busy bit under a bound
    task automatic cmd(input logic [31:0] c);
        int n;
        n = 0;
        wr(32'h10, c);
        do begin
            pm_u.xfer(1'b0, 32'h1c, 32'h0, rv, ev);
            n++;
        end while (rv[0] !== 1'b0 && n < 20);
        if (rv[0] !== 1'b0) begin
            stuck <= 1'b1;
        end
    endtask

    task automatic lookup(input logic [31:0] key);
        wr(32'h18, key);
        cmd(32'h8);
    endtask

    always @(posedge hung or posedge stuck) begin
        mismatches++;
        results();
    end

    initial begin
        repeat (16) @(posedge pclk);
        check("power_down in reset", {31'h0, power_down}, 32'h1);
        check("match_flag in reset", {31'h0, match_flag}, 32'h0);
        presetn <= 1'b1;
        rdc("ctrl reset", 32'h0, 32'h0000_c080);
        rdc("care reset", 32'hc, 32'hffff_ffff);
        rdc("status reset", 32'h1c, 32'h0);
        $display("test reset done");
        wr(32'h4, 32'h5);
        wr(32'h8, 32'h1234);
        cmd(32'h1);
        wr(32'h4, 32'h6);
        cmd(32'h2);
        rdc("ram preload", 32'h14, 32'h5a06);
        wr(32'h4, 32'h5);
        cmd(32'h2);
        rdc("ram word", 32'h14, 32'h1234);
        wr(32'h0, 32'hc0a0);
        wr(32'h4, 32'h105);
        wr(32'h8, 32'hab);
        cmd(32'h1);
        cmd(32'h2);
        rdc("split upper", 32'h14, 32'hab34);
        wr(32'h4, 32'h5);
        wr(32'h8, 32'hcd);
        cmd(32'h1);
        wr(32'h0, 32'hc0c0);
        cmd(32'h2);
        rdc("split lower low power", 32'h14, 32'habcd);
        wr(32'h0, 32'hc082);
        wr(32'h4, 32'h9);
        wr(32'h8, 32'hffff);
        cmd(32'h1);
        wr(32'h0, 32'hc080);
        cmd(32'h2);
        rdc("rom unwritable", 32'h14, 32'h5a09);
        wr(32'h0, 32'hfc80);
        wr(32'h4, 32'ha);
        wr(32'h8, 32'h55aa);
        cmd(32'h1);
        cmd(32'h2);
        rdc("registered ram paths", 32'h14, 32'h55aa);
        $display("test ram done");
        rdc("unmapped read", 32'h24, 32'h0);
        check("unmapped error", {31'h0, ev}, 32'h1);
        rdc("aliased read", 32'h100, 32'h0);
        wr(32'h100, 32'h0);
        check("aliased write error", {31'h0, ev}, 32'h1);
        rdc("aliased write dropped", 32'h0, 32'h0000_fc80);
        wr(32'h0, 32'hc000);
        rdc("status powered down", 32'h1c, 32'h80);
        wr(32'h10, 32'h2);
        check("command refused", {31'h0, ev}, 32'h1);
        $display("test refusal done");
        wr(32'h0, 32'hc091);
        wr(32'h4, 32'd20);
        wr(32'h8, 32'hdead_beef);
        cmd(32'h4);
        wr(32'h18, 32'hdead_beef);
        wr(32'h10, 32'h8);
        rdc("lookup encoded", 32'h1c, 32'h52);
        check("match flag", {31'h0, match_flag}, 32'h1);
        lookup(32'h3);
        rdc("preloaded word", 32'h1c, 32'h0e);
        lookup(32'h1f);
        rdc("last word", 32'h1c, 32'h7e);
        lookup(32'h1234_5678);
        rdc("no match", 32'h1c, 32'h0, 32'h2);
        wr(32'hc, 32'hffff_0000);
        wr(32'h4, 32'h7);
        wr(32'h8, 32'hcafe_0000);
        cmd(32'h4);
        wr(32'hc, 32'hffff_ffff);
        lookup(32'hcafe_1234);
        rdc("dont care", 32'h1c, 32'h1e);
        $display("test cam single done");
        wr(32'h0, 32'hc081);
        lookup(32'h5ead_beef);
        rdc("even bank", 32'h20, 32'h400);
        lookup(32'hdead_beef);
        rdc("odd bank miss", 32'h20, 32'h0);
        lookup(32'h8000_0015);
        rdc("odd bank hit", 32'h20, 32'h400);
        wr(32'h0, 32'hc085);
        wr(32'h4, 32'h5);
        wr(32'h8, 32'hdead_beef);
        cmd(32'h4);
        lookup(32'hdead_beef);
        rdc("multi lines", 32'h20, 32'h0004_0400);
        wr(32'h0, 32'hc095);
        lookup(32'hdead_beef);
        rdc("multi lowest", 32'h1c, 32'h16);
        wr(32'h0, 32'hc089);
        lookup(32'hdead_beef);
        rdc("fast lines", 32'h20, 32'h20);
        wr(32'h0, 32'h4089);
        lookup(32'h0);
        rdc("output gate off", 32'h20, 32'h20);
        wr(32'h0, 32'hc389);
        lookup(32'h0);
        rdc("registered paths", 32'h20, 32'h1);
        $display("test cam modes done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("power_down second reset", {31'h0, power_down}, 32'h1);
        check("match_flag second reset", {31'h0, match_flag}, 32'h0);
        presetn <= 1'b1;
        rdc("ctrl after reset", 32'h0, 32'h0000_c080);
        $display("test second reset done");
        results();
    end
endmodule

bind mem_block mem_block_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_flag(match_flag), .power_down(power_down));
